// *** include/rotate_mask_shift_alu_consts.svh ***
// Constants for the rotate/mask/shift ALU datapath.
// Assumes inclusion by bare name from package and design files.
`ifndef ROTATE_MASK_SHIFT_ALU_CONSTS_SVH
`define ROTATE_MASK_SHIFT_ALU_CONSTS_SVH
`define WORD_BITS        32
`define AMT_BITS         5
`define FUNC_BITS        8
`define CLASS_BITS       3
`define CLASS_COUNT      8
`define WORD_BITS_5      6'h20
// Opcode field positions inside the 32-bit base-set ALU word
`define OPERATION_CLASS_LSB     28
`define OP_ARITH_BIT     27
`define OP_FUNC_LSB      19
`define OP_SECOND_SOURCE_SEL_LSB  15
`define OP_IMM5_LSB      0
// Second-source kinds
`define SECOND_SOURCE_REG         2'h0
`define SECOND_SOURCE_IMM5        2'h1
`define SECOND_SOURCE_IMM32       2'h2
// Arithmetic codes in the odd function bits
`define ARITH_ADD        4'h6
`define ARITH_SUB        4'h9
`define ARITH_SHR_SIGNED 4'hc
`define MOD_SPLIT_BIT    0
`define MOD_ZERO_ALL_BIT 1
`endif

// *** include/rotate_mask_shift_alu_pkg.sv ***
// Types for the rotate/mask/shift ALU datapath.
// Assumes the constants header sits in the include path.
`include "rotate_mask_shift_alu_consts.svh"
package rotate_mask_shift_alu_pkg;
   typedef enum {SHIFT_NONE, ROT_LEFT, ROT_RIGHT, SHIFT_LEFT,
                 SHIFT_RIGHT_U, SHIFT_RIGHT_S, SHIFT_RIGHT_DEFAULT} shift_kind_type;
   typedef enum {ST_IDLE, ST_BUSY} state_type;
endpackage : rotate_mask_shift_alu_pkg

// *** src/mask_generator.sv ***
// Mask generator: n right-justified ones, optional zero-gives-all-ones.
// Assumes a 5-bit input; purely combinational.
`timescale 1ns/10ps
`include "rotate_mask_shift_alu_consts.svh"
module mask_generator #(
   parameter int WIDTH = `WORD_BITS
) (
   input  wire logic [4:0]       amount,
   input  wire logic             zero_all_ones,
   output logic      [WIDTH-1:0] mask
);
   initial begin
      if (WIDTH != 32) $error("mask_generator serves 32-bit words only");
   end
   ////////////////////////////////////////////////////////////////////////
   // Ones in the low n bits, zeros above
   always_comb begin
      mask = '0;
      for (int i = 0; i < WIDTH; i++) begin
         mask[i] = (i < int'(amount));
      end
      if (zero_all_ones && amount == 5'h00) begin
         mask = '1;
      end
   end
endmodule : mask_generator

// *** src/rotate_mask_shift_alu.sv ***
// Shift and rotate datapath with base-set ALU opcode decode.
// Assumes one core clock; operands are steady in the cycle they are given.
//
// How it works
// - Every shift and rotate goes through one 32-bit left barrel rotator.
// - Right rotate uses left rotate by two's complement of the amount.
// - Shifts combine rotator output on port B with mask on port C.
// - Left shift rotates left n and clears low n bits with inverted mask.
// - Register right shift: low five bits hold negated distance, feed rotator and mask.
// - Constant right shift k uses 32-k rotate and mask; zero returns operand.
// - Signed right shift alters ALU function by operand sign to fill sign bits.
// - Signed right shift works on full 32-bit words only, never split.
// - Right shift without signedness qualifier is treated as signed.
// - Second source is 5-bit immediate, 32-bit immediate, or data register.
// - Operation class selects one of eight ALU operand routings; here it is only decoded and output on OPERATION_CLASS.
// - Arithmetic bit set enables carry; clear selects carry-free Boolean.
// - Boolean function code is a truth table over three ALU inputs.
// - Arithmetic mode: odd bits choose operation, even bits choose modifiers.
// - Mask generator gives n low ones and zeros above.
// - Zero-all-ones modifier turns input zero into all ones.
`timescale 1ns/10ps
`include "rotate_mask_shift_alu_consts.svh"
module rotate_mask_shift_alu
   import rotate_mask_shift_alu_pkg::*;
#(
   parameter int WIDTH = `WORD_BITS
) (
   input  wire logic                     CLK,
   input  wire logic                     RST,
   input  wire logic                     START,
   input  wire logic [31:0]              OPCODE,
   input  wire logic [31:0]              FIRST_SOURCE,
   input  wire logic [31:0]              SECOND_SOURCE,
   input  wire logic [31:0]              IMMEDIATE_32,
   input  wire logic [31:0]              PORT_A_IN,
   input  wire logic [31:0]              SHIFT_AMOUNT_REGISTER,
   input  wire logic                     SHIFT_BY_REGISTER,
   input  wire logic [4:0]               SHIFT_CONSTANT,
   input  wire logic [2:0]               SHIFT_KIND,
   input  wire logic                     USE_SHIFT,
   input  wire logic                     PARALLEL_TRANSFER_REQ,
   output logic                          DONE,
   output logic [31:0]                   RESULT,
   output logic                          CARRY_OUT,
   output logic                          ARITH_ENABLE,
   output logic [2:0]                    OPERATION_CLASS,
   output logic [7:0]                    FUNCTION_CODE,
   output logic [1:0]                    SECOND_SOURCE_KIND,
   output logic                          PARALLEL_TRANSFER_ALLOWED,
   output logic                          ILLEGAL_COMBINATION
);
   initial begin
      if (WIDTH != 32) $error("rotate_mask_shift_alu serves 32-bit words only");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers used by several paths
   function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] n);
      logic [63:0] dbl;
      dbl  = {v, v} << n;
      rotl = dbl[63:32];
   endfunction : rotl

   function automatic logic [4:0] negate5(input logic [4:0] n);
      negate5 = 5'(~n + 5'h01);
   endfunction : negate5

   // Three-input truth table: bit index is {a,b,c}
   function automatic logic [31:0] bool3(input logic [7:0] f, input logic [31:0] a,
                                         input logic [31:0] b, input logic [31:0] c);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[i] = f[{a[i], b[i], c[i]}];
      end
      bool3 = r;
   endfunction : bool3

   ////////////////////////////////////////////////////////////////////////
   // Registered state
   typedef struct packed {
      state_type   state;
      logic        done;
      logic [31:0] result;
      logic        carry;
      logic        arith;
      logic [2:0]  operation_class;
      logic [7:0]  func;
      logic [1:0]  second_source_kind;
      logic        par_ok;
      logic        illegal;
   } regs_type;

   regs_type q, d;

   ////////////////////////////////////////////////////////////////////////
   // Opcode decode
   logic [2:0]  dec_class;
   logic        dec_arith;
   logic [7:0]  dec_func;
   logic [1:0]  dec_second_source;
   logic [3:0]  arith_op;
   logic [3:0]  modifiers;
   logic [31:0] second_source_val;

   always_comb begin
      dec_class = OPCODE[`OPERATION_CLASS_LSB +: `CLASS_BITS];
      dec_arith = OPCODE[`OP_ARITH_BIT];
      dec_func  = OPCODE[`OP_FUNC_LSB +: `FUNC_BITS];
      dec_second_source  = OPCODE[`OP_SECOND_SOURCE_SEL_LSB +: 2];
      arith_op  = {dec_func[7], dec_func[5], dec_func[3], dec_func[1]};
      modifiers = {dec_func[6], dec_func[4], dec_func[2], dec_func[0]};
      unique case (dec_second_source)
         `SECOND_SOURCE_IMM5:  second_source_val = {27'h0, OPCODE[`OP_IMM5_LSB +: 5]};
         `SECOND_SOURCE_IMM32: second_source_val = IMMEDIATE_32;
         default:     second_source_val = SECOND_SOURCE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Rotate amount and mask input selection
   shift_kind_type kind;
   logic [4:0]     amt_raw;
   logic [4:0]     rot_amt;
   logic [4:0]     mask_in;
   logic           zero_all;
   logic [31:0]    mask_c;

   always_comb begin
      unique case (SHIFT_KIND)
         3'h1:    kind = ROT_LEFT;
         3'h2:    kind = ROT_RIGHT;
         3'h3:    kind = SHIFT_LEFT;
         3'h4:    kind = SHIFT_RIGHT_U;
         3'h5:    kind = SHIFT_RIGHT_S;
         3'h6:    kind = SHIFT_RIGHT_DEFAULT;
         default: kind = SHIFT_NONE;
      endcase
      // Register amounts use the low five bits only
      amt_raw  = SHIFT_BY_REGISTER ? SHIFT_AMOUNT_REGISTER[4:0] : SHIFT_CONSTANT;
      rot_amt  = amt_raw;
      mask_in  = amt_raw;
      zero_all = 1'b0;
      unique case (kind)
         ROT_RIGHT: rot_amt = negate5(amt_raw);
         SHIFT_RIGHT_U, SHIFT_RIGHT_S, SHIFT_RIGHT_DEFAULT: begin
            if (SHIFT_BY_REGISTER) begin
               // Register already holds the negated distance
               zero_all = 1'b1;
            end else begin
               // Constant k encodes as 32-k; k of zero stays zero
               rot_amt = negate5(amt_raw);
               mask_in = negate5(amt_raw);
               zero_all = (amt_raw == 5'h00);
            end
         end
         default: ;
      endcase
   end

   mask_generator #(.WIDTH(WIDTH)) u_mask (
      .amount        (mask_in),
      .zero_all_ones (zero_all),
      .mask          (mask_c)
   );

   ////////////////////////////////////////////////////////////////////////
   // Datapath: rotator feeds port B, mask feeds port C
   logic [31:0] port_b;
   logic [31:0] shift_res;
   logic [32:0] sum;
   logic        sign_in;
   logic        bad;

   always_comb begin
      port_b  = rotl(FIRST_SOURCE, rot_amt);
      sign_in = FIRST_SOURCE[31];
      bad     = (dec_second_source == `SECOND_SOURCE_IMM32) && PARALLEL_TRANSFER_REQ;
      sum     = '0;
      unique case (kind)
         ROT_LEFT, ROT_RIGHT: shift_res = port_b;
         SHIFT_LEFT:          shift_res = port_b & ~mask_c;
         SHIFT_RIGHT_U:       shift_res = port_b & mask_c;
         // Sign picks AND with mask or OR with its inverse
         SHIFT_RIGHT_S, SHIFT_RIGHT_DEFAULT:
            shift_res = sign_in ? (port_b | ~mask_c) : (port_b & mask_c);
         default:             shift_res = FIRST_SOURCE;
      endcase
      // Signed shift is whole-word only; split modifier is refused
      if ((kind == SHIFT_RIGHT_S || kind == SHIFT_RIGHT_DEFAULT)
          && dec_arith && modifiers[`MOD_SPLIT_BIT]) begin
         bad = 1'b1;
      end
      // Boolean ops cannot use the zero-all-ones mask for unsigned register right shifts
      if (kind == SHIFT_RIGHT_U && SHIFT_BY_REGISTER && !dec_arith) begin
         bad = 1'b1;
      end
      if (!USE_SHIFT && dec_arith) begin
         unique case (arith_op)
            `ARITH_SUB: sum = {1'b0, PORT_A_IN} - {1'b0, second_source_val};
            default:    sum = {1'b0, PORT_A_IN} + {1'b0, second_source_val};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d      = q;
      d.done = 1'b0;
      unique case (q.state)
         ST_IDLE: begin
            if (START) begin
               d.state     = ST_BUSY;
               d.operation_class  = dec_class;
               d.arith     = dec_arith;
               d.func      = dec_func;
               d.second_source_kind = dec_second_source;
               d.par_ok    = (dec_second_source != `SECOND_SOURCE_IMM32);
               d.illegal   = bad;
               d.carry     = USE_SHIFT ? 1'b0 : (dec_arith & sum[32]);
               if (USE_SHIFT) begin
                  d.result = shift_res;
               end else if (dec_arith) begin
                  d.result = sum[31:0];
               end else begin
                  d.result = bool3(dec_func, PORT_A_IN, port_b, second_source_val);
               end
            end
         end
         ST_BUSY: begin
            d.state = ST_IDLE;
            d.done  = 1'b1;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         q <= '{state: ST_IDLE, done: 1'b0, result: 32'h0, carry: 1'b0, arith: 1'b0,
                operation_class: 3'h0, func: 8'h00, second_source_kind: 2'h0, par_ok: 1'b1,
                illegal: 1'b0};
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign DONE                      = q.done;
   assign RESULT                    = q.result;
   assign CARRY_OUT                 = q.carry;
   assign ARITH_ENABLE              = q.arith;
   assign OPERATION_CLASS           = q.operation_class;
   assign FUNCTION_CODE             = q.func;
   assign SECOND_SOURCE_KIND        = q.second_source_kind;
   assign PARALLEL_TRANSFER_ALLOWED = q.par_ok;
   assign ILLEGAL_COMBINATION       = q.illegal;
endmodule : rotate_mask_shift_alu

// *** testbench/rotate_mask_shift_alu_asserts.sv ***
// Checker for the shift ALU: ties outputs to the request that was taken.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
module shift_alu_checker #(
   parameter int WIDTH = 32
) (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        START,
   input wire logic [31:0] OPCODE,
   input wire logic [31:0] FIRST_SOURCE,
   input wire logic [31:0] SHIFT_AMOUNT_REGISTER,
   input wire logic        SHIFT_BY_REGISTER,
   input wire logic [4:0]  SHIFT_CONSTANT,
   input wire logic [2:0]  SHIFT_KIND,
   input wire logic        USE_SHIFT,
   input wire logic        PARALLEL_TRANSFER_REQ,
   input wire logic        DONE,
   input wire logic [31:0] RESULT,
   input wire logic        ARITH_ENABLE,
   input wire logic [2:0]  OPERATION_CLASS,
   input wire logic [7:0]  FUNCTION_CODE,
   input wire logic [1:0]  SECOND_SOURCE_KIND,
   input wire logic        PARALLEL_TRANSFER_ALLOWED,
   input wire logic        ILLEGAL_COMBINATION
);
   logic        busy_q;
   logic        take;
   logic [31:0] src_q;
   logic [31:0] op_q;
   logic [4:0]  amt_q;
   assign take = START && !busy_q;
   // Busy for one cycle after a take, so a held START is not a new request
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= take;
         if (take) begin
            src_q <= FIRST_SOURCE;
            op_q  <= OPCODE;
            amt_q <= SHIFT_CONSTANT;
         end
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_done_two: assert property (take |-> ##2 DONE) else $error("done late");
   a_done_pulse: assert property (DONE |=> !DONE) else $error("done too long");
   a_done_cause: assert property (DONE |-> $past(take, 2)) else $error("stray done");
   a_class_decode: assert property (take |=> OPERATION_CLASS == op_q[30:28])
      else $error("class decode wrong");
   a_func_decode: assert property (take |=> ARITH_ENABLE == op_q[27] &&
      FUNCTION_CODE == op_q[26:19] && SECOND_SOURCE_KIND == op_q[16:15]) else $error("func wrong");
   a_imm_parallel: assert property (take && OPCODE[16:15] == 2'h2 &&
      PARALLEL_TRANSFER_REQ |=> !PARALLEL_TRANSFER_ALLOWED && ILLEGAL_COMBINATION)
      else $error("wide immediate with transfer not flagged");
   a_result_hold: assert property (!take |=> $stable(RESULT)) else $error("result moved");
   a_rot_zero: assert property (take && USE_SHIFT && SHIFT_KIND inside {3'h1, 3'h2} &&
      (SHIFT_BY_REGISTER ? SHIFT_AMOUNT_REGISTER[4:0] : SHIFT_CONSTANT) == 5'h0
      |=> RESULT == src_q) else $error("zero rotate changed operand");
   a_shl_clear: assert property (take && USE_SHIFT && SHIFT_KIND == 3'h3 &&
      !SHIFT_BY_REGISTER |=> (RESULT & ((32'h1 << amt_q) - 32'h1)) == 32'h0)
      else $error("left shift low bits not cleared");
   a_shr_sign: assert property (take && USE_SHIFT && SHIFT_KIND inside {3'h5, 3'h6} &&
      FIRST_SOURCE[31] |=> RESULT[31]) else $error("signed shift lost sign");
endmodule : shift_alu_checker
bind rotate_mask_shift_alu shift_alu_checker #(.WIDTH(WIDTH)) u_chk (.CLK(CLK), .RST(RST),
   .START(START), .OPCODE(OPCODE), .FIRST_SOURCE(FIRST_SOURCE), .USE_SHIFT(USE_SHIFT),
   .SHIFT_AMOUNT_REGISTER(SHIFT_AMOUNT_REGISTER), .SHIFT_BY_REGISTER(SHIFT_BY_REGISTER),
   .SHIFT_CONSTANT(SHIFT_CONSTANT), .SHIFT_KIND(SHIFT_KIND), .DONE(DONE), .RESULT(RESULT),
   .PARALLEL_TRANSFER_REQ(PARALLEL_TRANSFER_REQ), .ARITH_ENABLE(ARITH_ENABLE),
   .OPERATION_CLASS(OPERATION_CLASS), .FUNCTION_CODE(FUNCTION_CODE),
   .SECOND_SOURCE_KIND(SECOND_SOURCE_KIND), .ILLEGAL_COMBINATION(ILLEGAL_COMBINATION),
   .PARALLEL_TRANSFER_ALLOWED(PARALLEL_TRANSFER_ALLOWED));

// *** testbench/rotate_mask_shift_alu_tb.sv ***
// Self-checking bench: boundary and random shifts against a behavioural model.
// Assumes one 40 MHz clock, results one cycle and DONE two cycles after a take.
`timescale 1ns/10ps
module rotate_mask_shift_alu_tb;
   logic        clk, rst, start, by_reg, use_shift, pt_req, done, carry, arith, pta, ill;
   logic [31:0] opcode, fs, s2, imm32, pa, amt_reg, result;
   logic [4:0]  k;
   logic [2:0]  kind, operation_class;
   logic [7:0]  func;
   logic [1:0]  s2_kind;
   int          error_cnt, checks_done, cyc, seed, i;
   rotate_mask_shift_alu #(.WIDTH(32)) u_dut (.CLK(clk), .RST(rst), .START(start),
      .OPCODE(opcode), .FIRST_SOURCE(fs), .SECOND_SOURCE(s2), .IMMEDIATE_32(imm32),
      .PORT_A_IN(pa), .SHIFT_AMOUNT_REGISTER(amt_reg), .SHIFT_BY_REGISTER(by_reg),
      .SHIFT_CONSTANT(k), .SHIFT_KIND(kind), .USE_SHIFT(use_shift),
      .PARALLEL_TRANSFER_REQ(pt_req), .DONE(done), .RESULT(result), .CARRY_OUT(carry),
      .ARITH_ENABLE(arith), .OPERATION_CLASS(operation_class), .FUNCTION_CODE(func),
      .SECOND_SOURCE_KIND(s2_kind), .PARALLEL_TRANSFER_ALLOWED(pta),
      .ILLEGAL_COMBINATION(ill));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rotl(input logic [31:0] v, input int n);
      return (v << n) | (v >> (32 - n));
   endfunction : rotl
   // Register right amounts arrive negated; constants are turned round here
   function automatic logic [31:0] model(input logic [31:0] v, input int kd, input int e,
                                         input bit rg);
      logic [31:0] m;
      int          r;
      r = rg ? e : (32 - e) % 32;
      m = (r == 0) ? 32'hffffffff : ((32'h1 << r) - 32'h1);
      case (kd)
         0: return v;
         1: return rotl(v, e);
         2: return rotl(v, (32 - e) % 32);
         3: return rotl(v, e) & ~((32'h1 << e) - 32'h1);
         default: return (rotl(v, r) & m) | ((kd != 4 && v[31]) ? ~m : 32'h0);
      endcase
   endfunction : model
   // ALU path: add or subtract picked by the odd code bits, else a truth table over {A,B,C}
   function automatic logic [32:0] alu_model(input logic [31:0] a, input logic [31:0] b,
                                             input logic [31:0] c, input logic [31:0] op);
      logic [32:0] r;
      r = '0;
      if (op[27] && {op[26], op[24], op[22], op[20]} == 4'h9) begin
         r = {1'b0, a} - {1'b0, c};
      end else if (op[27]) begin
         r = {1'b0, a} + {1'b0, c};
      end else begin
         for (int j = 0; j < 32; j++) begin
            r[j] = op[19 + {a[j], b[j], c[j]}];
         end
      end
      return r;
   endfunction : alu_model
   task automatic check(input bit ok, input string what);
      checks_done++;
      if (!ok) begin
         error_cnt++;
         $display("Error at %0t: %s mismatch", $time, what);
      end
   endtask : check
   // One request; START is held through the busy cycle with a changed operand
   task automatic run_op();
      logic [31:0] exp_r;
      logic        exp_ill;
      logic [31:0] second_source;
      logic [32:0] exp_alu;
      exp_r = model(fs, kind, by_reg ? amt_reg[4:0] : k, by_reg);
      // Second ALU source as chosen by the opcode's source-kind field
      second_source = (opcode[16:15] == 2'h1) ? {27'h0, opcode[4:0]} :
             (opcode[16:15] == 2'h2) ? imm32 : s2;
      // With no shift kind the rotator takes the raw amount on port B
      exp_alu = alu_model(pa, rotl(fs, by_reg ? amt_reg[4:0] : k), second_source, opcode);
      if (!use_shift) begin
         exp_r = exp_alu[31:0];
      end
      exp_ill = (opcode[16:15] == 2'h2 && pt_req) || (opcode[27] && opcode[19] && kind >= 5)
                || (!opcode[27] && kind == 3'h4 && by_reg);
      start = 1'b1;
      @(posedge clk);
      #2;
      fs = ~fs;
      @(posedge clk);
      #2;
      check(done === 1'b1, "done");
      check(result === exp_r, "result");
      check(carry === (!use_shift && exp_alu[32]), "carry");
      check(operation_class === opcode[30:28] && arith === opcode[27], "class");
      check(func === opcode[26:19] && s2_kind === opcode[16:15], "func");
      check(pta === (opcode[16:15] != 2'h2) && ill === exp_ill, "flags");
      start = 1'b0;
      @(posedge clk);
      #2;
   endtask : run_op
   task automatic conclude();
      $display("Checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Cuts a hang short: the whole run needs about a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         error_cnt++;
         conclude();
      end
   end
   initial begin
      seed = 47819;
      {rst, start, opcode, fs, s2, imm32, pa, amt_reg, k, by_reg, pt_req} = '0;
      {error_cnt, checks_done, cyc} = '0;
      rst = 1'b1;
      kind = 3'h1;
      use_shift = 1'b1;
      repeat (10) @(posedge clk);
      #2;
      check(pta === 1'b1 && done === 1'b0 && result === 32'h0 && carry === 1'b0
            && ill === 1'b0, "reset");
      rst = 1'b0;
      // Zero and largest amounts for every kind, from constant and register
      for (i = 0; i < 24; i++) begin
         opcode = 32'h88000000;
         fs = $random(seed);
         kind = 3'(i % 6 + 1);
         by_reg = (i / 6) % 2;
         k = (i >= 12) ? 5'h1f : 5'h00;
         amt_reg = {27'($random(seed)), k};
         run_op();
      end
      // Random opcodes, operands and amounts, every kind and source kind
      for (i = 0; i < 200; i++) begin
         opcode = $random(seed);
         opcode[16:15] = 2'(($random(seed) & 32'h7fff) % 3);
         {fs, s2, imm32, pa, amt_reg} = {$random(seed), $random(seed), $random(seed),
                                         $random(seed), $random(seed)};
         k = 5'($random(seed));
         kind = 3'(1 + ($random(seed) & 32'h7fff) % 6);
         {by_reg, pt_req, use_shift} = {1'($random(seed)), 1'($random(seed)), 1'b1};
         run_op();
      end
      // Reset again in mid-run: every output but func and s2_kind is checked at its idle value
      rst = 1'b1;
      @(posedge clk);
      #2;
      check(pta === 1'b1 && done === 1'b0 && result === 32'h0 && carry === 1'b0
            && ill === 1'b0 && operation_class === 3'h0 && arith === 1'b0, "mid reset");
      rst = 1'b0;
      // ALU path: Boolean and arithmetic codes, subtract forced every fourth request
      for (i = 0; i < 100; i++) begin
         opcode = $random(seed);
         opcode[16:15] = 2'(($random(seed) & 32'h7fff) % 3);
         if (i % 4 == 0) begin
            {opcode[27], opcode[26], opcode[24], opcode[22], opcode[20]} = 5'h19;
         end
         {fs, s2, imm32, pa, amt_reg} = {$random(seed), $random(seed), $random(seed),
                                         $random(seed), $random(seed)};
         k = 5'($random(seed));
         kind = 3'h0;
         {by_reg, pt_req, use_shift} = {1'($random(seed)), 1'($random(seed)), 1'(i % 8 == 7)};
         run_op();
      end
      conclude();
   end
endmodule : rotate_mask_shift_alu_tb
